// >>> shared/gdfs_regs.svh
`ifndef GDFS_REGS_SVH
`define GDFS_REGS_SVH
`define GDFS_RESET_TIME_NS 350000
`define GDFS_CLK_PERIOD_NS 100
`define GDFS_RESET_CYCLES ((`GDFS_RESET_TIME_NS + `GDFS_CLK_PERIOD_NS - 1) / `GDFS_CLK_PERIOD_NS)
`endif

// >>> shared/gdfs_pkg.sv
package gdfs_pkg;
   typedef enum logic [1:0] {
      GDFS_ST_OFF = 2'b00,
      GDFS_ST_RAILS = 2'b01,
      GDFS_ST_RUN = 2'b10
   } gdfs_state_t;
endpackage : gdfs_pkg

// >>> hdl/gdfs_low_timer.sv
`include "gdfs_regs.svh"
module gdfs_low_timer #(
   parameter int unsigned RESET_CYCLES = `GDFS_RESET_CYCLES
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic cmd_i,
   output logic done_o
);
   localparam int unsigned CW = $clog2(RESET_CYCLES + 1);
   localparam logic [CW-1:0] TERM = CW'(RESET_CYCLES);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   always_comb begin
      next_count = count;
      if (cmd_i) begin
         next_count = '0;
      end else if (count != TERM) begin
         next_count = count + CW'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign done_o = (count == TERM);
endmodule : gdfs_low_timer

// >>> hdl/gdfs_supervisor.sv
`include "gdfs_regs.svh"
module gdfs_supervisor #(
   parameter int unsigned RESET_CYCLES = `GDFS_RESET_CYCLES,
   parameter bit CYCLE_BY_CYCLE = 1'b0
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic cmd_i,
   input wire logic over_temp_i,
   input wire logic temp_below_low_i,
   input wire logic overcurrent_trip_i,
   input wire logic main_uv_i,
   input wire logic aux_regulator_rail_uv_i,
   input wire logic negative_gate_rail_uv_i,
   input wire logic safety_fet_on_i,
   output logic switch_on_o,
   output logic converter_en_o,
   output logic aux_regulator_en_o,
   output logic safety_fet_en_o,
   output logic thermal_fault_o,
   output logic overcurrent_fault_o,
   output logic health_n_o,
   output logic health_oe_o
);
   gdfs_pkg::gdfs_state_t state;
   gdfs_pkg::gdfs_state_t next_state;
   logic ot_latch;
   logic next_ot_latch;
   logic oc_latch;
   logic next_oc_latch;
   logic switch_on;
   logic next_switch_on;
   logic conv_en;
   logic next_conv_en;
   logic aux_en;
   logic next_aux_en;
   logic health;
   logic next_health;
   logic low_done;
   logic any_uv;

   gdfs_low_timer #(
      .RESET_CYCLES(RESET_CYCLES)
   ) u_timer (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cmd_i(cmd_i),
      .done_o(low_done)
   );

   // Any rail below its lockout threshold
   function automatic logic rail_low(
      input logic main_uv,
      input logic aux_uv,
      input logic neg_uv
   );
      return main_uv | aux_uv | neg_uv;
   endfunction : rail_low

   // Release of the overcurrent latch for the chosen variant
   function automatic logic oc_release(
      input logic cycle_mode,
      input logic cmd,
      input logic timer_done,
      input logic supply_gone
   );
      logic release_now;
      release_now = 1'b0;
      if (cycle_mode) begin
         release_now = !cmd;
      end else begin
         // Long low input or loss of the main supply
         release_now = timer_done | supply_gone;
      end
      return release_now;
   endfunction : oc_release

   // Flag reads ready only in run with healthy rails and no latched fault
   function automatic logic ready_flag(
      input gdfs_pkg::gdfs_state_t st,
      input logic uv,
      input logic ot,
      input logic oc
   );
      return (st == gdfs_pkg::GDFS_ST_RUN) && !uv && !ot && !oc;
   endfunction : ready_flag

   assign any_uv = rail_low(main_uv_i, aux_regulator_rail_uv_i, negative_gate_rail_uv_i);

   always_comb begin
      next_state = state;
      unique case (state)
         gdfs_pkg::GDFS_ST_OFF: begin
            if (!any_uv) begin
               next_state = gdfs_pkg::GDFS_ST_RAILS;
            end
         end
         gdfs_pkg::GDFS_ST_RAILS: begin
            if (any_uv) begin
               next_state = gdfs_pkg::GDFS_ST_OFF;
            end else if (safety_fet_on_i) begin
               next_state = gdfs_pkg::GDFS_ST_RUN;
            end
         end
         gdfs_pkg::GDFS_ST_RUN: begin
            if (any_uv) begin
               next_state = gdfs_pkg::GDFS_ST_OFF;
            end
         end
         default: next_state = gdfs_pkg::GDFS_ST_OFF;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state <= gdfs_pkg::GDFS_ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Thermal latch
   always_comb begin
      next_ot_latch = ot_latch;
      if (ot_latch && temp_below_low_i && low_done) begin
         next_ot_latch = 1'b0;
      end
      // Set after clear so a fresh trip wins
      if (over_temp_i) begin
         next_ot_latch = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ot_latch <= 1'b0;
      end else begin
         ot_latch <= next_ot_latch;
      end
   end

   // Overcurrent latch
   always_comb begin
      next_oc_latch = oc_latch;
      if (oc_latch && oc_release(CYCLE_BY_CYCLE, cmd_i, low_done, main_uv_i)) begin
         next_oc_latch = 1'b0;
      end
      // Set after clear so a fresh trip wins
      if (overcurrent_trip_i) begin
         next_oc_latch = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         oc_latch <= 1'b0;
      end else begin
         oc_latch <= next_oc_latch;
      end
   end

   // Negative-rail converter enable
   always_comb begin
      next_conv_en = !main_uv_i && !aux_regulator_rail_uv_i;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         conv_en <= 1'b0;
      end else begin
         conv_en <= next_conv_en;
      end
   end

   // Auxiliary regulator enable
   always_comb begin
      next_aux_en = !main_uv_i;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         aux_en <= 1'b0;
      end else begin
         aux_en <= next_aux_en;
      end
   end

   // Health flag follows the next state and latches
   always_comb begin
      next_health = ready_flag(next_state, any_uv, next_ot_latch, next_oc_latch);
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         health <= 1'b0;
      end else begin
         health <= next_health;
      end
   end

   // Switch needs the flag high now and next, and no live trip
   always_comb begin
      next_switch_on = cmd_i && health && next_health && !over_temp_i && !overcurrent_trip_i;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         switch_on <= 1'b0;
      end else begin
         switch_on <= next_switch_on;
      end
   end

   assign switch_on_o = switch_on;
   assign converter_en_o = conv_en;
   assign aux_regulator_en_o = aux_en;
   assign safety_fet_en_o = (state != gdfs_pkg::GDFS_ST_OFF);
   assign thermal_fault_o = ot_latch;
   assign overcurrent_fault_o = oc_latch;
   assign health_n_o = health;
   assign health_oe_o = 1'b1;
endmodule : gdfs_supervisor

// >>> dv/gdfs_pwm.sv
module gdfs_pwm (
   input logic clock_i,
   input logic en_i,
   input logic health_n_i,
   output logic cmd_o
);
   timeunit 1ns / 1ns;
   logic [7:0] age = 8'h00;
   always @(posedge clock_i) begin
      age <= health_n_i === 1'b1 ? age + 8'h01 : 8'h00; // Idle until flag high
      cmd_o <= en_i && age[2:0] < age[7:5]; // Duty widens slowly
   end
endmodule : gdfs_pwm

// >>> dv/gdfs_props.sv
module gdfs_props (
   input logic clock_i, sys_rst_i, cmd_i, over_temp_i, overcurrent_trip_i, main_uv_i,
   input logic aux_regulator_rail_uv_i, negative_gate_rail_uv_i, switch_on_o, converter_en_o,
   input logic aux_regulator_en_o, thermal_fault_o, overcurrent_fault_o, health_n_o
);
   timeunit 1ns / 1ns;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   hot_trip_a: assert property (over_temp_i |=> thermal_fault_o && !switch_on_o) else $error("hot");
   flag_low_a: assert property (thermal_fault_o || overcurrent_fault_o |-> !health_n_o) else $error("flag");
   rail_off_a: assert property (main_uv_i || aux_regulator_rail_uv_i || negative_gate_rail_uv_i
      |=> !health_n_o && !switch_on_o) else $error("uv");
   main_uv_a: assert property (main_uv_i |=> !aux_regulator_en_o && !converter_en_o) else $error("main");
   aux_uv_a: assert property (aux_regulator_rail_uv_i |=> !converter_en_o) else $error("aux");
   cmd_gate_a: assert property (switch_on_o |-> $past(cmd_i) && $past(health_n_o)) else $error("gate");
   oc_trip_a: assert property (overcurrent_trip_i |=> overcurrent_fault_o && !switch_on_o) else $error("oc");
   rail_up_a: assert property ($rose(health_n_o) |-> !$past(main_uv_i)) else $error("up");
   cover property ($rose(health_n_o));
   cover property ($fell(thermal_fault_o));
   cover property (switch_on_o);
endmodule : gdfs_props
bind gdfs_supervisor gdfs_props i_props (.*);

// >>> dv/testbench.sv
module testbench;
   timeunit 1ns / 1ns;
   logic clock_i, sys_rst_i, cmd_i, over_temp_i, temp_below_low_i, overcurrent_trip_i, safety_fet_on_i;
   logic switch_on_o, converter_en_o, aux_regulator_en_o, thermal_fault_o, overcurrent_fault_o, health_n_o;
   logic health_oe_o, safety_fet_en_o, en;
   logic [2:0] uv;
   int bad_count, cmp_count, cycles;
   gdfs_supervisor #(.RESET_CYCLES(8)) i_dut (.main_uv_i(uv[0]), .aux_regulator_rail_uv_i(uv[1]),
      .negative_gate_rail_uv_i(uv[2]), .*);
   gdfs_pwm i_pwm (.clock_i, .en_i(en), .health_n_i(health_n_o), .cmd_o(cmd_i));
   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %h %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d bad %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #10;
      cycles += n;
      if (cycles > 200) begin
         bad_count++;
         report_and_stop();
      end
   endtask : tick
   initial forever #50 clock_i = ~clock_i;
   initial begin
      {clock_i, sys_rst_i, over_temp_i, temp_below_low_i, overcurrent_trip_i, safety_fet_on_i, en, uv} = 10'h100;
      tick(5);
      sys_rst_i = 1'b0;
      tick(4);
      chk(health_n_o, 1'b0);
      chk(safety_fet_en_o, 1'b1);
      chk(switch_on_o, 1'b0);
      {safety_fet_on_i, en} = 2'h3;
      tick(50);
      chk(health_n_o & health_oe_o, 1'b1);
      $display("startup done");
      {over_temp_i, overcurrent_trip_i} = 2'h3;
      tick(1);
      {over_temp_i, overcurrent_trip_i} = 2'h0;
      tick(6);
      chk(thermal_fault_o, 1'b1);
      chk(health_n_o | switch_on_o, 1'b0);
      {en, temp_below_low_i} = 2'h1;
      tick(12);
      chk(thermal_fault_o | overcurrent_fault_o, 1'b0);
      $display("faults done");
      for (int i = 0; i < 3; i++) begin
         uv = 3'h1 << i;
         tick(2);
         chk(converter_en_o, i == 2);
         chk(aux_regulator_en_o, i != 0);
      end
      uv = 3'h0;
      tick(4);
      chk(health_n_o, 1'b1);
      $display("rails done");
      report_and_stop();
   end
endmodule : testbench
